// [srss_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module srss_bench;
    import srss_pkg::*;
    localparam int DEB  = 3;
    localparam int IDLE = 20;
    logic mclk, rst_b, core_power_good, smbus_busy, sleep_state, sleep_request;
    logic link_mode_serial, deep_sleep_state, deep_sleep_pd_cfg, clock_stop_request;
    logic power_stable, reset_button, regulator_at_max, wake_request, need_clock;
    logic platform_ready, system_reset, throttle_request, wake_event, low_power_go;
    logic clocks_running, isolate_outputs, memory_self_refresh, link_reset_seen;
    logic pull_down_seen;
    int   miscompares, n_compared;

    srss_if pins ();
    srss_device #(.DEBOUNCE(DEB), .IDLE_WAIT(IDLE), .WARN_LEAD(WARN_LEAD_CYC)) srss_device_inst (
        .mclk, .rst_b, .pins, .core_power_good, .smbus_busy, .sleep_state, .sleep_request,
        .link_mode_serial, .deep_sleep_state, .deep_sleep_pd_cfg, .clock_stop_request,
        .platform_ready, .system_reset, .throttle_request, .wake_event, .low_power_go,
        .clocks_running);
    srss_platform srss_platform_inst (
        .mclk, .rst_b, .pins, .power_stable, .reset_button, .regulator_at_max, .wake_request,
        .need_clock, .isolate_outputs, .memory_self_refresh, .link_reset_seen, .pull_down_seen);
    srss_props #(.DEBOUNCE(DEB), .IDLE_WAIT(IDLE), .WARN_LEAD(WARN_LEAD_CYC)) srss_props_inst (
        .mclk, .rst_b, .system_power_good(pins.system_power_good),
        .system_reset_request_n(pins.system_reset_request_n),
        .regulator_alert_n(pins.regulator_alert_n), .wake_i(pins.wake_i),
        .bus_clock_out(pins.bus_clock_out), .suspend_status_n(pins.suspend_status_n),
        .smbus_busy, .sleep_state, .link_mode_serial, .system_reset, .throttle_request,
        .wake_event, .low_power_go);

    // 10 MHz
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic summarize();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // sample 1 ns past the edge so the design's updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // bounded wait; running out ends the run as a mismatch
    task automatic await(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v) begin
            if (n == lim) begin
                chk(32'(s), 32'(v));
                summarize();
            end
            tick(1);
            n++;
        end
    endtask

    task automatic t_power();
        int n;
        @(posedge mclk) core_power_good <= 1'b1;
        tick(12);
        chk(32'(system_reset), 32'h1);
        @(posedge mclk) begin
            power_stable    <= 1'b1;
            core_power_good <= 1'b0;
        end
        tick(12);
        chk(32'(system_reset), 32'h1);
        @(posedge mclk) core_power_good <= 1'b1;
        await(system_reset, 1'b0, 20, n);
        chk(32'(platform_ready), 32'h1);
    endtask
    // a too-short glitch first, then a held request
    task automatic t_rst(input logic busy, input int lo, input int hi);
        int n;
        @(posedge mclk) smbus_busy <= busy;
        @(posedge mclk) reset_button <= 1'b1;
        repeat (DEB - 1) @(posedge mclk);
        reset_button <= 1'b0;
        tick(8);
        chk(32'(system_reset), 32'h0);
        @(posedge mclk) reset_button <= 1'b1;
        await(system_reset, 1'b1, hi, n);
        chk(32'(n >= lo), 32'h1);
        @(posedge mclk) reset_button <= 1'b0;
        await(system_reset, 1'b0, DEB + 8, n);
        @(posedge mclk) smbus_busy <= 1'b0;
    endtask
    task automatic t_throttle();
        int n;
        @(posedge mclk) regulator_at_max <= 1'b1;
        await(throttle_request, 1'b1, 4, n);
        chk(32'(pins.regulator_alert_n), 32'h0);
        @(posedge mclk) regulator_at_max <= 1'b0;
        await(throttle_request, 1'b0, 4, n);
    endtask
    // awake first: the same edge must then give no event
    task automatic t_wake();
        logic hit;
        for (int s = 0; s < 2; s++) begin
            @(posedge mclk) sleep_state <= s[0];
            @(posedge mclk) wake_request <= 1'b1;
            hit = 1'b0;
            repeat (8) begin
                tick(1);
                hit = hit | wake_event;
            end
            chk(32'(hit), 32'(s));
            chk(32'(pins.wake_i), 32'h0);
            @(posedge mclk) wake_request <= 1'b0;
            tick(4);
        end
        @(posedge mclk) sleep_state <= 1'b0;
    endtask
    task automatic t_clock();
        int   n;
        logic seen;
        @(posedge mclk) clock_stop_request <= 1'b1;
        await(clocks_running, 1'b0, STOP_IDLE_CYC + 8, n);
        tick(2);
        chk(32'(pins.bus_clock_out), 32'h0);
        chk(32'(pins.clkrun_i), 32'h1);
        @(posedge mclk) need_clock <= 1'b1;
        await(clocks_running, 1'b1, 6, n);
        seen = 1'b0;
        repeat (6) begin
            tick(1);
            seen = seen | pins.bus_clock_out[0];
        end
        chk(32'(seen), 32'h1);
        @(posedge mclk) clock_stop_request <= 1'b0;
        @(posedge mclk) need_clock <= 1'b0;
        tick(3);
        chk(32'(pins.clkrun_i), 32'h0);
        chk(32'(clocks_running), 32'h1);
    endtask
    task automatic t_suspend();
        int n;
        @(posedge mclk) sleep_request <= 1'b1;
        await(isolate_outputs, 1'b1, 4, n);
        chk(32'(pins.suspend_status_n), 32'h0);
        chk(32'(memory_self_refresh), 32'h1);
        chk(32'(low_power_go), 32'h0);
        await(low_power_go, 1'b1, WARN_LEAD_CYC + 2, n);
        @(posedge mclk) sleep_request <= 1'b0;
        await(isolate_outputs, 1'b0, 4, n);
    endtask
    task automatic t_serial();
        int n;
        @(posedge mclk) link_mode_serial <= 1'b1;
        tick(3);
        chk(32'(link_reset_seen), 32'h0);
        @(posedge mclk) reset_button <= 1'b1;
        await(link_reset_seen, 1'b1, DEB + 8, n);
        @(posedge mclk) reset_button <= 1'b0;
        await(link_reset_seen, 1'b0, DEB + 8, n);
        @(posedge mclk) link_mode_serial <= 1'b0;
    endtask
    task automatic t_pulldown();
        for (int c = 0; c < 4; c++) begin
            @(posedge mclk) {deep_sleep_state, deep_sleep_pd_cfg} <= c[1:0];
            tick(4);
            chk(32'(pull_down_seen), 32'(c == 3));
        end
    endtask

    initial begin
        rst_b = 1'b0;
        {core_power_good, smbus_busy, sleep_state, sleep_request, link_mode_serial} = 5'h0;
        {deep_sleep_state, deep_sleep_pd_cfg, clock_stop_request, power_stable} = 4'h0;
        {reset_button, regulator_at_max, wake_request, need_clock} = 4'h0;
        miscompares = 0;
        n_compared = 0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        t_power();
        t_rst(1'b0, DEB + 1, DEB + 5);
        t_rst(1'b1, DEB + IDLE, DEB + IDLE + 6);
        t_throttle();
        t_wake();
        t_clock();
        t_suspend();
        t_serial();
        t_pulldown();
        summarize();
    end
endmodule
`default_nettype wire

// [srss_device.sv]
// Operation
// - reset exit waits for both power-goods
// - debounce reset request, then internal reset
// - idle bus: reset applied at once
// - busy bus: wait 25 ms, then force
// - regulator alert raises throttle request
// - falling wake pin in sleep state gives wake event
// - clock-run line governs both bus clocks
// - suspend status asserted before low power
// - memories may use suspend for self-refresh
// - peripherals isolate outputs on suspend status
// - serial link mode: pin is link reset
// - deep-sleep pull-downs enabled by configuration
`timescale 1ns/1ps
`default_nettype none
module srss_device
    import srss_pkg::*;
#(
    parameter int DEBOUNCE  = DEBOUNCE_CYC,
    parameter int IDLE_WAIT = IDLE_WAIT_CYC,
    parameter int WARN_LEAD = WARN_LEAD_CYC
) (
    input  wire logic mclk,
    input  wire logic rst_b,
    srss_if.dev       pins,
    input  wire logic core_power_good,
    input  wire logic smbus_busy,
    input  wire logic sleep_state,
    input  wire logic sleep_request,
    input  wire logic link_mode_serial,
    input  wire logic deep_sleep_state,
    input  wire logic deep_sleep_pd_cfg,
    input  wire logic clock_stop_request,
    output logic      platform_ready,
    output logic      system_reset,
    output logic      throttle_request,
    output logic      wake_event,
    output logic      low_power_go,
    output logic      clocks_running
);
    srss_rst_t   st;
    srss_rst_t   next_st;
    logic [31:0] deb_cnt;
    logic [31:0] next_deb_cnt;
    logic        deb_req;
    logic        next_deb_req;
    logic [31:0] wait_cnt;
    logic [31:0] next_wait_cnt;
    logic        next_system_reset;
    logic        next_platform_ready;
    logic        next_throttle_request;
    logic        wake_prev;
    logic        next_wake_prev;
    logic        next_wake_event;
    logic [31:0] warn_cnt;
    logic [31:0] next_warn_cnt;
    logic        sus_n;
    logic        next_sus_n;
    logic        next_low_power_go;
    logic        next_pd;
    logic [1:0]  div_cnt;
    logic [1:0]  next_div_cnt;
    logic [1:0]  clk_out;
    logic [1:0]  next_clk_out;
    logic        run;
    logic        next_run;
    logic [31:0] stop_cnt;
    logic [31:0] next_stop_cnt;
    logic        clkrun_oe_n;
    logic        next_clkrun_oe_n;

    // reset request debounce, internal reset sequencing
    always_comb begin
        next_deb_cnt = deb_cnt;
        next_deb_req = deb_req;
        if (pins.system_reset_request_n == deb_req) begin
            // raw level differs from settled state; must stay put long enough
            if (deb_cnt >= 32'(DEBOUNCE - 1)) begin
                next_deb_req = ~pins.system_reset_request_n;
                next_deb_cnt = 32'h0000_0000;
            end else begin
                next_deb_cnt = deb_cnt + 32'h0000_0001;
            end
        end else begin
            next_deb_cnt = 32'h0000_0000;
        end
        next_platform_ready = core_power_good & pins.system_power_good;
        next_st = st;
        next_wait_cnt = wait_cnt;
        next_system_reset = system_reset;
        case (st)
            SRSS_IDLE: begin
                if (!platform_ready) begin
                    next_system_reset = 1'b1;
                end else if (deb_req) begin
                    if (!smbus_busy) begin
                        next_st = SRSS_RESET;
                        next_system_reset = 1'b1;
                    end else begin
                        next_st = SRSS_WAIT;
                        next_wait_cnt = 32'h0000_0000;
                    end
                end else begin
                    next_system_reset = 1'b0;
                end
            end
            SRSS_WAIT: begin
                next_wait_cnt = wait_cnt + 32'h0000_0001;
                if (!smbus_busy || wait_cnt >= 32'(IDLE_WAIT - 1)) begin
                    next_st = SRSS_RESET;
                    next_system_reset = 1'b1;
                end
            end
            SRSS_RESET: begin
                next_system_reset = 1'b1;
                next_st = SRSS_HOLD;
            end
            SRSS_HOLD: begin
                // hold reset until the request is released, avoids retrigger
                if (!deb_req) begin
                    next_st = SRSS_IDLE;
                end
            end
            default: begin
                next_st = SRSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st             <= SRSS_IDLE;
            deb_cnt        <= 32'h0000_0000;
            deb_req        <= 1'b0;
            wait_cnt       <= 32'h0000_0000;
            system_reset   <= 1'b1;
            platform_ready <= 1'b0;
        end else begin
            st             <= next_st;
            deb_cnt        <= next_deb_cnt;
            deb_req        <= next_deb_req;
            wait_cnt       <= next_wait_cnt;
            system_reset   <= next_system_reset;
            platform_ready <= next_platform_ready;
        end
    end

    // alert, wake, suspend status, pull-downs
    always_comb begin
        next_throttle_request = ~pins.regulator_alert_n;
        next_wake_prev = pins.wake_i;
        next_wake_event = sleep_state & wake_prev & ~pins.wake_i;
        next_warn_cnt = warn_cnt;
        next_sus_n = sus_n;
        next_low_power_go = 1'b0;
        if (link_mode_serial) begin
            next_sus_n = ~system_reset;
            next_warn_cnt = 32'h0000_0000;
        end else if (sleep_request) begin
            next_sus_n = 1'b0;
            // warning lead so peripherals can isolate before power drops
            if (warn_cnt == 32'(WARN_LEAD - 1)) begin
                next_low_power_go = 1'b1;
                next_warn_cnt = warn_cnt + 32'h0000_0001;
            end else if (warn_cnt < 32'(WARN_LEAD)) begin
                next_warn_cnt = warn_cnt + 32'h0000_0001;
            end
        end else begin
            next_sus_n = 1'b1;
            next_warn_cnt = 32'h0000_0000;
        end
        next_pd = deep_sleep_state & deep_sleep_pd_cfg;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            throttle_request      <= 1'b0;
            wake_prev             <= 1'b1;
            wake_event            <= 1'b0;
            warn_cnt              <= 32'h0000_0000;
            sus_n                 <= RST_SUS_N;
            low_power_go          <= 1'b0;
            pins.pull_down_en     <= 1'b0;
        end else begin
            throttle_request      <= next_throttle_request;
            wake_prev             <= next_wake_prev;
            wake_event            <= next_wake_event;
            warn_cnt              <= next_warn_cnt;
            sus_n                 <= next_sus_n;
            low_power_go          <= next_low_power_go;
            pins.pull_down_en     <= next_pd;
        end
    end
    assign pins.suspend_status_n = sus_n;

    // bus clock divider with clock-run control
    always_comb begin
        next_div_cnt = div_cnt + 2'h1;
        next_clk_out = clk_out;
        next_run = run;
        next_stop_cnt = stop_cnt;
        if (!pins.clkrun_i) begin
            // a peripheral holds the line low: restart or keep running
            next_run = 1'b1;
            next_stop_cnt = 32'h0000_0000;
        end else if (clock_stop_request && run) begin
            if (stop_cnt >= 32'(STOP_IDLE_CYC - 1)) begin
                next_run = 1'b0;
            end else begin
                next_stop_cnt = stop_cnt + 32'h0000_0001;
            end
        end else if (!clock_stop_request) begin
            next_run = 1'b1;
            next_stop_cnt = 32'h0000_0000;
        end
        // hold the line low while running; let go to offer a stop; the release is registered, so
        // our own drive reads back once, in the first cycle of a stop request, and clears the stop count
        next_clkrun_oe_n = ~run | clock_stop_request;
        if (div_cnt == 2'(CLK_DIV_CYC / 2 - 1) || div_cnt == 2'(CLK_DIV_CYC - 1)) begin
            next_clk_out = run ? {2{~clk_out[0]}} : 2'h0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt     <= 2'h0;
            clk_out     <= 2'h0;
            run         <= 1'b1;
            stop_cnt    <= 32'h0000_0000;
            clkrun_oe_n <= 1'b1;
        end else begin
            div_cnt     <= next_div_cnt;
            clk_out     <= next_clk_out;
            run         <= next_run;
            stop_cnt    <= next_stop_cnt;
            clkrun_oe_n <= next_clkrun_oe_n;
        end
    end
    assign pins.bus_clock_out   = clk_out;
    assign pins.clkrun_o_dev    = 1'b0;
    assign pins.clkrun_oe_n_dev = clkrun_oe_n; // released while stopping or stopped
    assign clocks_running       = run;
endmodule
`default_nettype wire

// [srss_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface srss_if;
    logic system_power_good;
    logic system_reset_request_n;
    logic regulator_alert_n;
    logic wake_o;
    logic wake_oe_n;
    logic wake_i;
    logic clkrun_o_dev;
    logic clkrun_oe_n_dev;
    logic clkrun_o_plat;
    logic clkrun_oe_n_plat;
    logic clkrun_i;
    logic [1:0] bus_clock_out;
    logic suspend_status_n;
    logic pull_down_en;

    // open-drain wires resolve low when any end drives low
    assign wake_i   = (wake_oe_n == 1'b0) ? wake_o : 1'b1;
    assign clkrun_i = ((clkrun_oe_n_dev == 1'b0 && clkrun_o_dev == 1'b0) ||
                       (clkrun_oe_n_plat == 1'b0 && clkrun_o_plat == 1'b0)) ? 1'b0 : 1'b1;

    modport dev (
        input  system_power_good, system_reset_request_n, regulator_alert_n, wake_i,
        input  clkrun_i,
        output clkrun_o_dev, clkrun_oe_n_dev, bus_clock_out, suspend_status_n,
        output pull_down_en
    );
    modport plat (
        output system_power_good, system_reset_request_n, regulator_alert_n, wake_o,
        output wake_oe_n, clkrun_o_plat, clkrun_oe_n_plat,
        input  clkrun_i, bus_clock_out, suspend_status_n, pull_down_en
    );
endinterface
`default_nettype wire

// [srss_pkg.sv]
`default_nettype none
package srss_pkg;
    // timing figures, clock 10 MHz
    localparam int CLK_HZ          = 10_000_000;
    localparam int IDLE_WAIT_MS    = 25;
    localparam int IDLE_WAIT_CYC   = (CLK_HZ / 1000) * IDLE_WAIT_MS;
    localparam int DEBOUNCE_CYC    = 16;
    localparam int WARN_LEAD_CYC   = 8;
    localparam int CLK_DIV_CYC     = 4;
    localparam int STOP_IDLE_CYC   = 8;
    // reset values
    localparam logic RST_OUT_N     = 1'b0;
    localparam logic RST_SUS_N     = 1'b1;

    typedef enum logic [1:0] {
        SRSS_IDLE  = 2'b00,
        SRSS_WAIT  = 2'b01,
        SRSS_RESET = 2'b10,
        SRSS_HOLD  = 2'b11
    } srss_rst_t;
endpackage
`default_nettype wire

// [srss_platform.sv]
`timescale 1ns/1ps
`default_nettype none
module srss_platform
    import srss_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_b,
    srss_if.plat      pins,
    input  wire logic power_stable,
    input  wire logic reset_button,
    input  wire logic regulator_at_max,
    input  wire logic wake_request,
    input  wire logic need_clock,
    output logic      isolate_outputs,
    output logic      memory_self_refresh,
    output logic      link_reset_seen,
    output logic      pull_down_seen
);
    logic next_pg;
    logic next_rst_n;
    logic next_alert_n;
    logic next_wake_oe_n;
    logic next_clk_oe_n;
    logic next_iso;
    logic pg;
    logic rst_n;
    logic alert_n;
    logic wake_oe_n;
    logic clk_oe_n;

    // drive sideband levels, react to suspend status
    always_comb begin
        next_pg        = power_stable;
        next_rst_n     = ~reset_button;
        next_alert_n   = ~regulator_at_max;
        next_wake_oe_n = ~wake_request;
        next_clk_oe_n  = ~need_clock;
        next_iso       = ~pins.suspend_status_n;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pg                  <= 1'b0;
            rst_n               <= 1'b1;
            alert_n             <= 1'b1;
            wake_oe_n           <= 1'b1;
            clk_oe_n            <= 1'b1;
            isolate_outputs     <= 1'b0;
            memory_self_refresh <= 1'b0;
            link_reset_seen     <= 1'b0;
            pull_down_seen      <= 1'b0;
        end else begin
            pg                  <= next_pg;
            rst_n               <= next_rst_n;
            alert_n             <= next_alert_n;
            wake_oe_n           <= next_wake_oe_n;
            clk_oe_n            <= next_clk_oe_n;
            isolate_outputs     <= next_iso;
            memory_self_refresh <= next_iso;
            link_reset_seen     <= next_iso;
            pull_down_seen      <= pins.pull_down_en;
        end
    end
    assign pins.system_power_good      = pg;
    assign pins.system_reset_request_n = rst_n;
    assign pins.regulator_alert_n      = alert_n;
    assign pins.wake_o                 = 1'b0;
    assign pins.wake_oe_n              = wake_oe_n;
    assign pins.clkrun_o_plat          = 1'b0;
    assign pins.clkrun_oe_n_plat       = clk_oe_n;
endmodule
`default_nettype wire

// [srss_props.sv]
`timescale 1ns/1ps
`default_nettype none
module srss_props
    import srss_pkg::*;
#(
    parameter int DEBOUNCE  = DEBOUNCE_CYC,
    parameter int IDLE_WAIT = IDLE_WAIT_CYC,
    parameter int WARN_LEAD = WARN_LEAD_CYC
) (
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       system_power_good,
    input wire logic       system_reset_request_n,
    input wire logic       regulator_alert_n,
    input wire logic       wake_i,
    input wire logic [1:0] bus_clock_out,
    input wire logic       suspend_status_n,
    input wire logic       smbus_busy,
    input wire logic       sleep_state,
    input wire logic       link_mode_serial,
    input wire logic       system_reset,
    input wire logic       throttle_request,
    input wire logic       wake_event,
    input wire logic       low_power_go
);
    localparam int LEAD_LO = WARN_LEAD - 1;
    int req_cnt, ok_cnt, next_req_cnt, next_ok_cnt;

    // held-request run lengths; the idle one restarts on any busy cycle
    always_comb begin
        next_req_cnt = (system_power_good && !system_reset_request_n) ? req_cnt + 1 : 0;
        next_ok_cnt  = (next_req_cnt != 0 && !smbus_busy) ? ok_cnt + 1 : 0;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            req_cnt <= 0;
            ok_cnt  <= 0;
        end else begin
            req_cnt <= next_req_cnt;
            ok_cnt  <= next_ok_cnt;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_wake_fall;
        sleep_state ##0 $fell(wake_i);
    endsequence
    sequence s_warn_start;
        !link_mode_serial ##0 $fell(suspend_status_n);
    endsequence

    pg_gate_a: assert property (!system_power_good [*3] |-> system_reset)
        else $error("reset released without power good");
    idle_reset_a: assert property (ok_cnt >= DEBOUNCE + 3 |-> system_reset)
        else $error("idle bus reset late");
    busy_limit_a: assert property (req_cnt >= DEBOUNCE + IDLE_WAIT + 4 |-> system_reset)
        else $error("busy bus reset not forced");
    throttle_a: assert property (!regulator_alert_n |=> throttle_request)
        else $error("alert without throttle");
    wake_a: assert property (s_wake_fall |-> ##[1:2] wake_event)
        else $error("wake edge missed");
    clock_pair_a: assert property (bus_clock_out[0] == bus_clock_out[1])
        else $error("bus clocks differ");
    warn_lead_a: assert property (s_warn_start |-> ##[LEAD_LO:WARN_LEAD] low_power_go)
        else $error("low power go off its lead");
    link_reset_a: assert property (link_mode_serial [*2] ##0 system_reset |=> !suspend_status_n)
        else $error("link reset not driven");
endmodule
`default_nettype wire
